// ==== hdl/eesa_ctrl.sv ====
// eeprom shadow load, write protection and extended write sequencer
//
// What this block does
// - copy eeprom into shadow at power-up
// - shadow sits 0x40 above eeprom address
// - unused shadow bits absent, read zero
// - shadow keeps no ecc check bits
// - shadow writes obey eeprom protection, except lock 0xC
// - reads always allowed, no key
// - unlock lasts until next reset
// - lock 0xC blocks eeprom, not shadow
// - lock 0x3 blocks eeprom and shadow
// - user word b permission table
// - user word a follows b if exempt
// - other words: key needed, blocked by lock
// - controller loads 32-bit word, held here
// - go bit launches the write
// - done flag set at write end
// - shadow write takes one synced cycle
// - denied or aborted write: done plus warning
// - done flag at bit 0 next byte
`timescale 1ns/10ps
`default_nettype none
`include "eesa_defs.svh"

module eesa_ctrl
  import eesa_pkg::*;
#(
  parameter int EE_WORDS = `EESA_EE_WORDS,
  parameter int EE_WRITE_CYC = `EESA_EE_WRITE_CYC,
  parameter logic [23:0] SHADOW_MASK = 24'hFFFFFF
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic regWrite,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWData,
  output logic [7:0] regRData,
  output logic eeRead,
  output logic eeWrite,
  output logic [5:0] eeAddr,
  output logic [31:0] eeWData,
  input wire logic [31:0] eeRData,
  input wire logic eeRdValid,
  input wire logic eeWrDone,
  input wire logic eeWrAbort,
  input wire logic [5:0] shadowRdAddr,
  output logic [23:0] shadowRdData,
  output logic loadDone
);

  localparam int TW = $clog2(EE_WRITE_CYC + 1);
  localparam logic [TW-1:0] TIMEOUT = TW'(EE_WRITE_CYC);

  // ************************************************
  // storage and state
  // ************************************************
  eesa_state_t state;
  logic [23:0] shadow [0:63];
  logic [7:0] extAddr;
  logic [31:0] extData;
  logic goSync;
  logic writeDone;
  logic xeeWarn;
  logic [3:0] cfgLock;
  logic cfgCud;
  logic cfgDel;
  logic cfgDur;
  logic [5:0] loadIndex;
  logic [TW-1:0] eeTimer;
  logic unlocked;
  logic eeLocked;
  logic shLocked;
  logic allowEe;
  logic allowSh;
  logic goAccept;
  logic writeFail;
  logic writeOk;
  logic eeFinish;
  logic eeTimeout;
  logic [7:0] next_regRData;

  // ************************************************
  // unlock and permission
  // ************************************************
  eesa_unlock u_unlock (
    .clk(clk),
    .sys_rst(sys_rst),
    .keyWrite(regWrite && (regAddr == `EESA_ADDR_KEY)),
    .keyByte(regWData),
    .unlocked(unlocked)
  );

  // lock 0xC only stops eeprom writes
  assign eeLocked = (cfgLock == `EESA_LOCK_EE) || (cfgLock == `EESA_LOCK_ALL);
  assign shLocked = (cfgLock == `EESA_LOCK_ALL);

  // shadow uses the same permission table
  eesa_access u_access_ee (
    .wordAddr(extAddr[5:0]),
    .keyOk(unlocked),
    .locked(eeLocked),
    .cud(cfgCud),
    .del(cfgDel),
    .dur(cfgDur),
    .allow(allowEe)
  );

  eesa_access u_access_sh (
    .wordAddr(extAddr[5:0]),
    .keyOk(unlocked),
    .locked(shLocked),
    .cud(cfgCud),
    .del(cfgDel),
    .dur(cfgDur),
    .allow(allowSh)
  );

  // ************************************************
  // go handling and write decode
  // ************************************************
  // go ignored while loading or busy
  assign goAccept = regWrite && (regAddr == `EESA_ADDR_EWCS)
                    && regWData[`EESA_EWCS_GO_BIT] && (state == EESA_IDLE) && !goSync;
  // out of range or not permitted target
  assign writeFail = goSync && (extAddr[`EESA_EXT_SPACE_BIT]
                     || (extAddr[`EESA_EXT_SHADOW_BIT] ? !allowSh : !allowEe));
  assign writeOk = goSync && !writeFail;
  assign eeTimeout = (state == EESA_EE_WAIT) && (eeTimer == TIMEOUT);
  assign eeFinish = (state == EESA_EE_WAIT) && (eeWrDone || eeWrAbort || eeTimeout);

  // one cycle synchroniser of the go request
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      goSync <= 1'b0;
    end else begin
      goSync <= goAccept;
    end
  end

  // ************************************************
  // sequencer
  // ************************************************
  // load every word then go idle
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state <= EESA_LOAD_REQ;
      loadIndex <= 6'h00;
    end else begin
      unique case (state)
        EESA_LOAD_REQ: begin
          state <= EESA_LOAD_WAIT;
        end
        EESA_LOAD_WAIT: begin
          if (eeRdValid) begin
            if (loadIndex == 6'(EE_WORDS - 1)) begin
              state <= EESA_IDLE;
            end else begin
              loadIndex <= loadIndex + 6'h01;
              state <= EESA_LOAD_REQ;
            end
          end
        end
        EESA_IDLE: begin
          if (writeOk && !extAddr[`EESA_EXT_SHADOW_BIT]) begin
            state <= EESA_EE_WAIT;
          end
        end
        EESA_EE_WAIT: begin
          if (eeFinish) begin
            state <= EESA_IDLE;
          end
        end
      endcase
    end
  end

  // eeprom port strobes and address
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      eeRead <= 1'b0;
      eeWrite <= 1'b0;
      eeAddr <= 6'h00;
      eeWData <= `EESA_RST_WORD;
    end else begin
      eeRead <= (state == EESA_LOAD_REQ);
      eeWrite <= 1'b0;
      if (state == EESA_LOAD_REQ) begin
        eeAddr <= loadIndex;
      end
      // launch held word to held address
      if (writeOk && !extAddr[`EESA_EXT_SHADOW_BIT]) begin
        eeWrite <= 1'b1;
        eeAddr <= extAddr[5:0];
        eeWData <= extData;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      eeTimer <= '0;
    end else if (state == EESA_EE_WAIT) begin
      eeTimer <= eeTimer + TW'(1);
    end else begin
      eeTimer <= '0;
    end
  end

  // load status is registered together with the shadow read port

  // ************************************************
  // shadow memory
  // ************************************************
  // shadow word indexed by address minus 0x40
  always_ff @(posedge clk) begin
    if ((state == EESA_LOAD_WAIT) && eeRdValid) begin
      shadow[loadIndex] <= eeRData[23:0] & SHADOW_MASK;
    end else if (writeOk && extAddr[`EESA_EXT_SHADOW_BIT]) begin
      // shadow write one cycle after sync
      shadow[extAddr[5:0]] <= extData[23:0] & SHADOW_MASK;
    end
  end

  // operating read port and load status
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      shadowRdData <= 24'h000000;
      loadDone <= 1'b0;
    end else begin
      shadowRdData <= shadow[shadowRdAddr];
      loadDone <= (state == EESA_IDLE) || (state == EESA_EE_WAIT);
    end
  end

  // ************************************************
  // protection fields from eeprom
  // ************************************************
  // exceptions and lock clear until loaded
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      {cfgDur, cfgDel, cfgCud, cfgLock} <= `EESA_CFG_RST;
    end else if ((state == EESA_LOAD_WAIT) && eeRdValid && (loadIndex == `EESA_CFG_WORD)) begin
      cfgLock <= eeRData[`EESA_CFG_LOCK_LSB +: 4];
      cfgCud <= eeRData[`EESA_CFG_CUD_BIT];
      cfgDel <= eeRData[`EESA_CFG_DEL_BIT];
      cfgDur <= eeRData[`EESA_CFG_DUR_BIT];
    end else if ((state == EESA_EE_WAIT) && eeWrDone && !eeWrAbort
                 && (eeAddr == `EESA_CFG_WORD)) begin
      // a new lock takes hold as soon as it is in eeprom
      cfgLock <= eeWData[`EESA_CFG_LOCK_LSB +: 4];
      cfgCud <= eeWData[`EESA_CFG_CUD_BIT];
      cfgDel <= eeWData[`EESA_CFG_DEL_BIT];
      cfgDur <= eeWData[`EESA_CFG_DUR_BIT];
    end
  end

  // ************************************************
  // direct registers
  // ************************************************
  // extended write address
  // assemble 32-bit word, msb byte first
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      extAddr <= `EESA_RST_BYTE;
      extData <= `EESA_RST_WORD;
    end else if (regWrite) begin
      unique case (regAddr)
        `EESA_ADDR_EWA: extAddr <= regWData;
        `EESA_ADDR_EWD0: extData[31:24] <= regWData;
        `EESA_ADDR_EWD1: extData[23:16] <= regWData;
        `EESA_ADDR_EWD2: extData[15:8] <= regWData;
        `EESA_ADDR_EWD3: extData[7:0] <= regWData;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      writeDone <= 1'b0;
    end else if (writeFail || (writeOk && extAddr[`EESA_EXT_SHADOW_BIT]) || eeFinish) begin
      writeDone <= 1'b1;
    end else if (goAccept) begin
      writeDone <= 1'b0;
    end
  end

  // warning on denial, abort or timeout
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      xeeWarn <= 1'b0;
    end else if (writeFail || (eeFinish && !eeWrDone)) begin
      xeeWarn <= 1'b1; // set wins over clear
    end else if (regWrite && (regAddr == `EESA_ADDR_WARN) && regWData[`EESA_WARN_XEE_BIT]) begin
      xeeWarn <= 1'b0;
    end
  end

  // reads never gated by key or lock
  // done flag in the byte after control
  always_comb begin
    next_regRData = 8'h00;
    unique case (regAddr)
      `EESA_ADDR_EWA: next_regRData = extAddr;
      `EESA_ADDR_EWD0: next_regRData = extData[31:24];
      `EESA_ADDR_EWD1: next_regRData = extData[23:16];
      `EESA_ADDR_EWD2: next_regRData = extData[15:8];
      `EESA_ADDR_EWD3: next_regRData = extData[7:0];
      `EESA_ADDR_EWCS: next_regRData[`EESA_EWCS_BUSY_BIT] = goSync || (state == EESA_EE_WAIT);
      `EESA_ADDR_EWST: begin
        next_regRData[`EESA_EWST_DONE_BIT] = writeDone;
        next_regRData[`EESA_EWST_UNLK_BIT] = unlocked;
      end
      `EESA_ADDR_WARN: next_regRData[`EESA_WARN_XEE_BIT] = xeeWarn;
      default: next_regRData = 8'h00;
    endcase
  end

  // registered read data, one cycle after address
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      regRData <= 8'h00;
    end else begin
      regRData <= next_regRData;
    end
  end

endmodule
`default_nettype wire

// ==== hdl/eesa_defs.svh ====
// register offsets, field positions, key bytes and timing for eeprom shadow access control
`ifndef EESA_DEFS_SVH
`define EESA_DEFS_SVH

// ************************************************
// direct register byte offsets
// ************************************************
`define EESA_ADDR_EWA 8'h02
`define EESA_ADDR_EWD0 8'h04
`define EESA_ADDR_EWD1 8'h05
`define EESA_ADDR_EWD2 8'h06
`define EESA_ADDR_EWD3 8'h07
`define EESA_ADDR_EWCS 8'h08
`define EESA_ADDR_EWST 8'h09
`define EESA_ADDR_WARN 8'h36
`define EESA_ADDR_KEY 8'h3C

// ************************************************
// field positions
// ************************************************
`define EESA_EWCS_GO_BIT 7
`define EESA_EWCS_BUSY_BIT 7
`define EESA_EWST_DONE_BIT 0
`define EESA_EWST_UNLK_BIT 1
`define EESA_WARN_XEE_BIT 0
`define EESA_EXT_SPACE_BIT 7
`define EESA_EXT_SHADOW_BIT 6
`define EESA_CFG_LOCK_LSB 0
`define EESA_CFG_CUD_BIT 4
`define EESA_CFG_DEL_BIT 5
`define EESA_CFG_DUR_BIT 6

// ************************************************
// word addresses and lock codes
// ************************************************
`define EESA_USER_B 6'h17
`define EESA_USER_A 6'h1F
`define EESA_CFG_WORD 6'h16
`define EESA_LOCK_NONE 4'h0
`define EESA_LOCK_EE 4'hC
`define EESA_LOCK_ALL 4'h3

// ************************************************
// unlock key bytes, in order
// ************************************************
`define EESA_KEY0 8'h00
`define EESA_KEY1 8'h27
`define EESA_KEY2 8'h81
`define EESA_KEY3 8'h1F
`define EESA_KEY4 8'h77
`define EESA_KEY_LAST 3'h4

// ************************************************
// reset values and timing
// ************************************************
`define EESA_RST_BYTE 8'h00
`define EESA_RST_WORD 32'h0000_0000
`define EESA_CFG_RST 7'h00
`define EESA_EE_WORDS 64
`define EESA_EE_WRITE_MS 24
`define EESA_CLK_KHZ 50000
`define EESA_EE_WRITE_CYC (`EESA_EE_WRITE_MS * `EESA_CLK_KHZ)

`endif

// ==== hdl/eesa_pkg.sv ====
// types shared by the eeprom shadow access control block
package eesa_pkg;

  // sequencer states
  typedef enum logic [1:0] {
    EESA_LOAD_REQ = 2'b00,
    EESA_LOAD_WAIT = 2'b01,
    EESA_IDLE = 2'b10,
    EESA_EE_WAIT = 2'b11
  } eesa_state_t;

endpackage

// ==== hdl/eesa_unlock.sv ====
// unlock key sequence detector, sticky until reset
`timescale 1ns/10ps
`default_nettype none
`include "eesa_defs.svh"

module eesa_unlock (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic keyWrite,
  input wire logic [7:0] keyByte,
  output logic unlocked
);

  logic [2:0] keyIndex;
  logic [7:0] expected;

  // expected byte for the current step
  always_comb begin
    unique case (keyIndex)
      3'h0: expected = `EESA_KEY0;
      3'h1: expected = `EESA_KEY1;
      3'h2: expected = `EESA_KEY2;
      3'h3: expected = `EESA_KEY3;
      3'h4: expected = `EESA_KEY4;
      default: expected = `EESA_KEY0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      keyIndex <= 3'h0;
      unlocked <= 1'b0;
    end else if (keyWrite && !unlocked) begin
      if (keyByte == expected) begin
        if (keyIndex == `EESA_KEY_LAST) begin
          unlocked <= 1'b1;
          keyIndex <= 3'h0;
        end else begin
          keyIndex <= keyIndex + 3'h1;
        end
      end else begin
        keyIndex <= (keyByte == `EESA_KEY0) ? 3'h1 : 3'h0; // wrong byte restarts
      end
    end
  end

endmodule
`default_nettype wire

// ==== hdl/eesa_access.sv ====
// write permission for one word given lock, exceptions and key state
`timescale 1ns/10ps
`default_nettype none
`include "eesa_defs.svh"

module eesa_access (
  input wire logic [5:0] wordAddr,
  input wire logic keyOk,
  input wire logic locked,
  input wire logic cud,
  input wire logic del,
  input wire logic dur,
  output logic allow
);

  logic userB;
  logic other;

  always_comb begin
    userB = locked ? (del && (dur || keyOk)) : (dur || keyOk);
    // ordinary words need key, no lock
    other = !locked && keyOk;
    if (wordAddr == `EESA_USER_B) begin
      allow = userB;
    end else if (wordAddr == `EESA_USER_A) begin
      // user word a follows b when exempt
      allow = cud ? userB : other;
    end else begin
      allow = other;
    end
  end

endmodule
`default_nettype wire

// ==== sim/eesa_ctrl_checker.sv ====
// assertion checker bound to the eeprom shadow access top
`timescale 1ns/10ps
`default_nettype none
`include "eesa_defs.svh"

module eesa_ctrl_checker #(
  parameter int EE_WORDS = 64
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regRData,
  input wire logic eeRead,
  input wire logic eeWrite,
  input wire logic [5:0] eeAddr,
  input wire logic loadDone
);
  logic [7:0] rdCount;

  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);

  // counts load reads since reset
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rdCount <= 8'h00;
    end else if (eeRead) begin
      rdCount <= rdCount + 8'h01;
    end
  end

  chk_reset_quiet: assert property (
    $fell(sys_rst) |-> !eeRead && !eeWrite && !loadDone)
    else $error("outputs busy right after reset");
  chk_load_count: assert property (
    $rose(loadDone) |-> rdCount == 8'(EE_WORDS))
    else $error("load read count wrong");
  chk_read_spacing: assert property (
    eeRead |=> !eeRead [*2])
    else $error("load read not waiting for data");
  chk_no_late_read: assert property (
    loadDone |-> !eeRead)
    else $error("read request after load");
  chk_write_pulse: assert property (
    eeWrite |=> !eeWrite)
    else $error("write request longer than a pulse");
  chk_no_load_write: assert property (
    !loadDone |-> !eeWrite)
    else $error("write request during load");
  chk_addr_hold: assert property (
    eeWrite |=> $stable(eeAddr) [*3])
    else $error("write address moved mid write");
  chk_key_zero: assert property (
    regAddr == `EESA_ADDR_KEY |=> regRData == 8'h00)
    else $error("key register read not zero");
endmodule

bind eesa_ctrl eesa_ctrl_checker #(.EE_WORDS(EE_WORDS)) chk_u (
  .clk(clk),
  .sys_rst(sys_rst),
  .regAddr(regAddr),
  .regRData(regRData),
  .eeRead(eeRead),
  .eeWrite(eeWrite),
  .eeAddr(eeAddr),
  .loadDone(loadDone)
);

`default_nettype wire

// ==== sim/eesa_ee_model.sv ====
// eeprom array model answering load reads and slow writes
`timescale 1ns/10ps
`default_nettype none

module eesa_ee_model #(
  parameter int RD_LAT = 3,
  parameter int WR_LAT = 20
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic eeRead,
  input wire logic eeWrite,
  input wire logic [5:0] eeAddr,
  input wire logic [31:0] eeWData,
  output logic [31:0] eeRData,
  output logic eeRdValid,
  output logic eeWrDone,
  output logic eeWrAbort,
  input wire logic abortNext
);
  logic [31:0] mem [64];
  logic [7:0] rdCnt;
  logic [7:0] wrCnt;
  logic [5:0] rdAddr;
  logic [5:0] wrAddr;
  logic [31:0] wrData;
  int nWr;

  // words carry check bits above bit 23
  initial begin
    for (int i = 0; i < 64; i++) begin
      mem[i] = {8'hFC, 2'b00, 6'(i), 16'h5A3C};
    end
    mem[6'h16] = 32'h0000_0000;
    nWr = 0;
  end

  always @(posedge clk) begin
    eeRdValid <= 1'b0;
    eeWrDone <= 1'b0;
    eeWrAbort <= 1'b0;
    eeRData <= ~eeRData; // data line not held after valid
    if (sys_rst) begin
      rdCnt <= 8'h00;
      wrCnt <= 8'h00;
    end else begin
      if (eeRead) begin
        rdCnt <= 8'(RD_LAT);
        rdAddr <= eeAddr;
      end else if (rdCnt != 8'h00) begin
        rdCnt <= rdCnt - 8'h01;
      end
      if (rdCnt == 8'h01) begin
        eeRdValid <= 1'b1;
        eeRData <= mem[rdAddr];
      end
      if (eeWrite) begin
        wrCnt <= 8'(WR_LAT);
        wrAddr <= eeAddr;
        wrData <= eeWData;
        nWr <= nWr + 1;
      end else if (wrCnt != 8'h00) begin
        wrCnt <= wrCnt - 8'h01;
      end
      if (wrCnt == 8'h01 && abortNext) begin
        eeWrAbort <= 1'b1;
      end else if (wrCnt == 8'h01) begin
        eeWrDone <= 1'b1;
        mem[wrAddr] <= wrData;
      end
    end
  end
endmodule

`default_nettype wire

// ==== sim/eeprom_shadow_access_control_tb_top.sv ====
// self-checking bench for the eeprom shadow access control block
`timescale 1ns/10ps
`default_nettype none
`include "eesa_defs.svh"

module eeprom_shadow_access_control_tb_top;
  logic clk = 1'b0;
  logic sys_rst, regWrite, eeRead, eeWrite, eeRdValid;
  logic eeWrDone, eeWrAbort, loadDone, abortNext;
  logic [7:0] regAddr, regWData, regRData;
  logic [5:0] eeAddr, shadowRdAddr;
  logic [31:0] eeWData, eeRData;
  logic [23:0] shadowRdData;
  logic [5:0] probe [4] = '{6'h00, 6'h05, 6'h16, 6'h3F};
  int mismatches = 0;
  int total_checks = 0;

  eesa_ctrl #(.EE_WORDS(64), .EE_WRITE_CYC(50)) dut_u (.clk(clk), .sys_rst(sys_rst),
    .regWrite(regWrite), .regAddr(regAddr), .regWData(regWData), .regRData(regRData),
    .eeRead(eeRead), .eeWrite(eeWrite), .eeAddr(eeAddr), .eeWData(eeWData),
    .eeRData(eeRData), .eeRdValid(eeRdValid), .eeWrDone(eeWrDone), .eeWrAbort(eeWrAbort),
    .shadowRdAddr(shadowRdAddr), .shadowRdData(shadowRdData), .loadDone(loadDone));

  eesa_ee_model mdl_u (.clk(clk), .sys_rst(sys_rst), .eeRead(eeRead), .eeWrite(eeWrite),
    .eeAddr(eeAddr), .eeWData(eeWData), .eeRData(eeRData), .eeRdValid(eeRdValid),
    .eeWrDone(eeWrDone), .eeWrAbort(eeWrAbort), .abortNext(abortNext));

  // free running clock
  always #10 clk = ~clk;

  // ********
  // tasks
  // ********
  task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    regWrite = 1'b1;
    regAddr = a;
    regWData = d;
    @(posedge clk);
    #1 regWrite = 1'b0;
    // idle edge so back to back writes never retoggle the strobe in one step
    @(posedge clk);
    #1;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    regAddr = a;
    @(posedge clk);
    #1 d = regRData;
  endtask

  task automatic sh(input logic [5:0] w, output logic [31:0] q);
    shadowRdAddr = w;
    @(posedge clk);
    #1 q = {8'h00, shadowRdData};
  endtask

  task automatic key();
    logic [7:0] seq [5] = '{8'h00, 8'h27, 8'h81, 8'h1F, 8'h77};
    foreach (seq[i]) wr(`EESA_ADDR_KEY, seq[i]);
  endtask

  task automatic unlockIs(input logic exp);
    logic [7:0] v;
    rd(`EESA_ADDR_EWST, v);
    check("unlocked", {31'h0, exp}, {31'h0, v[1]});
  endtask

  task automatic resetDut(input logic [31:0] cfg);
    int i;
    mdl_u.mem[6'h16] = cfg;
    sys_rst = 1'b1;
    repeat (10) @(posedge clk);
    #1 sys_rst = 1'b0;
    for (i = 0; i < 2000 && loadDone !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    if (i == 2000) begin
      check("load wait", 0, 1);
      give_verdict();
    end
  endtask

  // extended write, poll done, then judge warning and target
  task automatic xw(input logic [7:0] a, input logic [31:0] d, input logic ok);
    logic [7:0] v;
    logic [31:0] prior, now;
    logic ee, good;
    int n, i;
    ee = !a[6];
    good = ok && !(abortNext && ee);
    if (ee) prior = mdl_u.mem[a[5:0]];
    else sh(a[5:0], prior);
    n = mdl_u.nWr;
    wr(`EESA_ADDR_EWA, a);
    wr(`EESA_ADDR_EWD0, d[31:24]);
    wr(`EESA_ADDR_EWD1, d[23:16]);
    wr(`EESA_ADDR_EWD2, d[15:8]);
    wr(`EESA_ADDR_EWD3, d[7:0]);
    wr(`EESA_ADDR_EWCS, 8'h80);
    repeat (3) @(posedge clk);
    #1 rd(`EESA_ADDR_EWCS, v);
    check("busy", {31'h0, ee && ok}, {31'h0, v[7]});
    for (i = 0; i < 100; i++) begin
      rd(`EESA_ADDR_EWST, v);
      if (v[0] === 1'b1) break;
    end
    if (i == 100) begin
      check("done wait", 0, 1);
      give_verdict();
    end
    rd(`EESA_ADDR_WARN, v);
    check("xee", {31'h0, !good}, {31'h0, v[0]});
    if (v[0] === 1'b1) wr(`EESA_ADDR_WARN, 8'h01);
    check("ee writes", 32'(n + (ee && ok)), 32'(mdl_u.nWr));
    if (ee) now = mdl_u.mem[a[5:0]];
    else sh(a[5:0], now);
    check("target", !good ? prior : ee ? d : {8'h00, d[23:0]}, now);
  endtask

  // ********
  // main sequence
  // ********
  initial begin
    logic [7:0] v;
    logic [31:0] q;
    regWrite = 1'b0;
    regAddr = 8'h00;
    regWData = 8'h00;
    shadowRdAddr = 6'h00;
    abortNext = 1'b0;
    resetDut(32'h0000_0000);
    foreach (probe[i]) begin
      sh(probe[i], q);
      check("load", mdl_u.mem[probe[i]] & 32'h00FF_FFFF, q);
    end
    rd(`EESA_ADDR_EWST, v);
    check("status", 0, {24'h0, v});
    rd(`EESA_ADDR_KEY, v);
    check("key read", 0, {24'h0, v});
    xw(8'h45, 32'hA5C3_5A3C, 1'b0);
    xw(8'h05, 32'hA5C3_5A3C, 1'b0);
    wr(`EESA_ADDR_KEY, 8'h00);
    wr(`EESA_ADDR_KEY, 8'h27);
    wr(`EESA_ADDR_KEY, 8'h55);
    unlockIs(1'b0);
    key();
    unlockIs(1'b1);
    xw(8'h45, 32'hA5C3_5A3C, 1'b1);
    xw(8'h05, 32'h1234_5678, 1'b1);
    abortNext = 1'b1;
    xw(8'h06, 32'h1234_5678, 1'b1);
    abortNext = 1'b0;
    xw(8'h17, 32'h1234_5678, 1'b1);
    xw(8'h1F, 32'h1234_5678, 1'b1);
    $display("test lock_none done");
    resetDut(32'h0000_006C);
    unlockIs(1'b0);
    xw(8'h17, 32'hA5C3_5A3C, 1'b1);
    xw(8'h1F, 32'hA5C3_5A3C, 1'b0);
    xw(8'h45, 32'h1234_5678, 1'b0);
    key();
    xw(8'h45, 32'h1234_5678, 1'b1);
    xw(8'h05, 32'hA5C3_5A3C, 1'b0);
    $display("test lock_eeprom done");
    resetDut(32'h0000_0033);
    xw(8'h17, 32'h1234_5678, 1'b0);
    key();
    xw(8'h17, 32'h1234_5678, 1'b1);
    xw(8'h1F, 32'hA5C3_5A3C, 1'b1);
    xw(8'h45, 32'hA5C3_5A3C, 1'b0);
    xw(8'h05, 32'h1234_5678, 1'b0);
    $display("test lock_all done");
    give_verdict();
  end
endmodule

`default_nettype wire
